/* File: hdl/psram_host_pkg.sv */
// constants for the pseudo static RAM host controller
package psram_host_pkg;
  // bus geometry
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  // clock and pin input synchroniser depth
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES = 3;
  // fast grade limits, ns
  localparam int T_RC_55_NS = 55;
  localparam int T_AA_55_NS = 55;
  localparam int T_WC_55_NS = 55;
  localparam int T_PWE_55_NS = 45;
  localparam int T_SD_55_NS = 25;
  localparam int T_HZWE_55_NS = 20;
  // slow grade limits, ns
  localparam int T_RC_70_NS = 70;
  localparam int T_AA_70_NS = 70;
  localparam int T_WC_70_NS = 70;
  localparam int T_PWE_70_NS = 60;
  localparam int T_SD_70_NS = 30;
  localparam int T_HZWE_70_NS = 30;
  // refresh related limits
  localparam int DESELECT_GAP_NS = 5;
  localparam int REFRESH_WINDOW_NS = 15000;
  // least times round up to whole cycles
  localparam int RD_ACC_55_CYC = (T_AA_55_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_ACC_70_CYC = (T_AA_70_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC_55_CYC = (T_RC_55_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC_70_CYC = (T_RC_70_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC_55_CYC = (T_WC_55_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC_70_CYC = (T_WC_70_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strobe must exceed turn-off plus setup, and meet its own minimum
  localparam int PULSE_55_NS = (T_PWE_55_NS > T_HZWE_55_NS + T_SD_55_NS) ?
                               T_PWE_55_NS : T_HZWE_55_NS + T_SD_55_NS + 1;
  localparam int PULSE_70_NS = (T_PWE_70_NS > T_HZWE_70_NS + T_SD_70_NS) ?
                               T_PWE_70_NS : T_HZWE_70_NS + T_SD_70_NS + 1;
  localparam int WR_PULSE_55_CYC = (PULSE_55_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_70_CYC = (PULSE_70_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (DESELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time rounds down
  localparam int REFRESH_WINDOW_CYC = REFRESH_WINDOW_NS / CLK_PERIOD_NS;
  // counter width for phase timing
  localparam int CNT_W = 8;

  // controller phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ACTIVE,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_GAP
  } phase_t;
endpackage

/* File: hdl/psram_pin_sync.sv */
// three-stage synchroniser for pin inputs with agreement flag
`timescale 1ns/1ns
`default_nettype none
module psram_pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut,
  output logic settled
);
  logic [WIDTH-1:0] stage1; // metastable catch, read only by stage2
  logic [WIDTH-1:0] stage2; // first resolved copy

  // shift the pin value through three flops
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      syncOut <= '0;
    end else if (ce) begin
      stage1 <= pinIn;
      stage2 <= stage1;
      syncOut <= stage2;
    end
  end

  // a value counts once the second and third stages agree; the first stays private
  assign settled = (stage2 == syncOut);
endmodule // psram_pin_sync
`default_nettype wire

/* File: hdl/psram_async_cycle_refresh.sv */
// host controller driving asynchronous read and write cycles
`timescale 1ns/1ns
`default_nettype none
module psram_async_cycle_refresh #(
  parameter bit SLOW_GRADE = 1'b1 // 1: 70 ns part, 0: 55 ns part
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // user request side
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [psram_host_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [psram_host_pkg::DATA_W-1:0] reqWrData,
  input wire logic [psram_host_pkg::LANES-1:0] reqLaneEn,
  output logic reqReady,
  output logic rspValid,
  output logic [psram_host_pkg::DATA_W-1:0] rspRdData,
  // memory pins
  output logic [psram_host_pkg::ADDR_W-1:0] memAddr,
  output logic chip_select_low_n,
  output logic chip_select_high,
  output logic output_drive_enable_n,
  output logic write_strobe_n,
  output logic low_byte_enable_n,
  output logic high_byte_enable_n,
  output logic [psram_host_pkg::DATA_W-1:0] dqOut,
  output logic dqOe,
  input wire logic [psram_host_pkg::DATA_W-1:0] dqIn
);
  // grade dependent cycle counts
  localparam int RD_ACC = SLOW_GRADE ? psram_host_pkg::RD_ACC_70_CYC
                                     : psram_host_pkg::RD_ACC_55_CYC;
  localparam int RD_MIN = SLOW_GRADE ? psram_host_pkg::RD_CYC_70_CYC
                                     : psram_host_pkg::RD_CYC_55_CYC;
  localparam int WR_PULSE = SLOW_GRADE ? psram_host_pkg::WR_PULSE_70_CYC
                                       : psram_host_pkg::WR_PULSE_55_CYC;
  localparam int WR_MIN = SLOW_GRADE ? psram_host_pkg::WR_CYC_70_CYC
                                     : psram_host_pkg::WR_CYC_55_CYC;
  // read holds select for access plus synchroniser latency, at least a cycle time
  localparam int RD_HOLD_RAW = RD_ACC + psram_host_pkg::SYNC_STAGES;
  localparam int RD_HOLD = (RD_HOLD_RAW > RD_MIN) ? RD_HOLD_RAW : RD_MIN;
  // write select span: setup, pulse, hold; the gap takes up any shortfall to the write cycle time
  localparam int WR_SPAN_RAW = WR_PULSE + 2;
  localparam int WR_EXTRA = (WR_SPAN_RAW >= WR_MIN) ? 0 : WR_MIN - WR_SPAN_RAW;
  localparam int GAP_LEN = psram_host_pkg::GAP_CYC + WR_EXTRA;

  // sized counter loads
  localparam logic [psram_host_pkg::CNT_W-1:0] RD_LOAD = psram_host_pkg::CNT_W'(RD_HOLD - 1);
  localparam logic [psram_host_pkg::CNT_W-1:0] PULSE_LOAD =
    psram_host_pkg::CNT_W'(WR_PULSE - 1);
  localparam logic [psram_host_pkg::CNT_W-1:0] GAP_LOAD = psram_host_pkg::CNT_W'(GAP_LEN - 1);
  localparam logic [psram_host_pkg::CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [psram_host_pkg::CNT_W-1:0] CNT_ONE = 8'h01;

  psram_host_pkg::phase_t phase; // current bus phase
  psram_host_pkg::phase_t next_phase; // phase for next cycle
  logic [psram_host_pkg::CNT_W-1:0] phaseCnt; // cycles left in phase
  logic [psram_host_pkg::DATA_W-1:0] dqSync; // synchronised read data
  logic dqSettled; // stages two and three agree
  logic phaseDone; // current timed phase expires
  logic accept; // request taken this cycle

  // read data pins pass three flops before use
  psram_pin_sync #(
    .WIDTH(psram_host_pkg::DATA_W)
  ) dqSyncInst (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pinIn(dqIn),
    .syncOut(dqSync),
    .settled(dqSettled)
  );

  assign phaseDone = (phaseCnt == CNT_ZERO);
  assign accept = reqValid && reqReady && (phase == psram_host_pkg::ST_IDLE);

  // phase sequencing
  always_comb begin
    next_phase = phase;
    unique case (phase)
      // idle: memory deselected, free to refresh
      psram_host_pkg::ST_IDLE: begin
        if (accept) begin
          next_phase = reqWrite ? psram_host_pkg::ST_WR_SETUP : psram_host_pkg::ST_RD_ACTIVE;
        end
      end
      // read: wait out access, latency and agreement of synchroniser
      psram_host_pkg::ST_RD_ACTIVE: begin
        if (phaseDone && dqSettled) begin
          next_phase = psram_host_pkg::ST_GAP;
        end
      end
      // one cycle of qualifiers before the strobe
      psram_host_pkg::ST_WR_SETUP: begin
        next_phase = psram_host_pkg::ST_WR_PULSE;
      end
      // strobe low for its full width
      psram_host_pkg::ST_WR_PULSE: begin
        if (phaseDone) begin
          next_phase = psram_host_pkg::ST_WR_HOLD;
        end
      end
      // strobe high ends the write, rest held
      psram_host_pkg::ST_WR_HOLD: begin
        next_phase = psram_host_pkg::ST_GAP;
      end
      // deselected gap lets refresh run
      psram_host_pkg::ST_GAP: begin
        if (phaseDone) begin
          next_phase = psram_host_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // phase register
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= psram_host_pkg::ST_IDLE;
    end else if (ce) begin
      phase <= next_phase;
    end
  end

  // phase timer, loaded on each phase entry
  always_ff @(posedge clk) begin
    if (rst) begin
      phaseCnt <= CNT_ZERO;
    end else if (ce) begin
      if (phase != next_phase) begin
        unique case (next_phase)
          psram_host_pkg::ST_RD_ACTIVE: phaseCnt <= RD_LOAD; // spacing of reads
          psram_host_pkg::ST_WR_PULSE: phaseCnt <= PULSE_LOAD;
          psram_host_pkg::ST_GAP: phaseCnt <= GAP_LOAD; // break of at least 5 ns
          default: phaseCnt <= CNT_ZERO;
        endcase
      end else if (!phaseDone) begin
        phaseCnt <= phaseCnt - CNT_ONE;
      end
    end
  end

  // ready only while idle and not about to leave it
  always_ff @(posedge clk) begin
    if (rst) begin
      reqReady <= 1'b0;
    end else if (ce) begin
      reqReady <= (next_phase == psram_host_pkg::ST_IDLE) && !accept;
    end
  end

  // address and byte lanes latched at acceptance, held until deselect
  always_ff @(posedge clk) begin
    if (rst) begin
      memAddr <= '0;
      low_byte_enable_n <= 1'b1;
      high_byte_enable_n <= 1'b1;
    end else if (ce) begin
      if (accept) begin
        // address valid with the select edge
        memAddr <= reqAddr;
        // lane 0 on bits 7:0, lane 1 on bits 15:8
        low_byte_enable_n <= !reqLaneEn[0];
        high_byte_enable_n <= !reqLaneEn[1];
      end else if (next_phase == psram_host_pkg::ST_GAP ||
                   next_phase == psram_host_pkg::ST_IDLE) begin
        low_byte_enable_n <= 1'b1;
        high_byte_enable_n <= 1'b1;
      end
    end
  end

  // chip selects: active for the whole access, dropped in gap and idle
  always_ff @(posedge clk) begin
    if (rst) begin
      chip_select_low_n <= 1'b1;
      chip_select_high <= 1'b0;
    end else if (ce) begin
      // selected before the strobe and after it ends
      chip_select_low_n <= (next_phase == psram_host_pkg::ST_IDLE) ||
                           (next_phase == psram_host_pkg::ST_GAP);
      chip_select_high <= !((next_phase == psram_host_pkg::ST_IDLE) ||
                            (next_phase == psram_host_pkg::ST_GAP));
    end
  end

  // write strobe low only in the pulse phase, never in reads
  always_ff @(posedge clk) begin
    if (rst) begin
      write_strobe_n <= 1'b1;
    end else if (ce) begin
      // rising strobe terminates the write
      write_strobe_n <= (next_phase != psram_host_pkg::ST_WR_PULSE);
    end
  end

  // output enable low only during reads, keeps memory off the bus in writes
  always_ff @(posedge clk) begin
    if (rst) begin
      output_drive_enable_n <= 1'b1;
    end else if (ce) begin
      output_drive_enable_n <= (next_phase != psram_host_pkg::ST_RD_ACTIVE);
    end
  end

  // write data driven from setup through hold
  always_ff @(posedge clk) begin
    if (rst) begin
      dqOut <= '0;
      dqOe <= 1'b0;
    end else if (ce) begin
      if (accept && reqWrite) begin
        dqOut <= reqWrData;
      end
      // data stable the whole pulse, held past the end
      dqOe <= (next_phase == psram_host_pkg::ST_WR_SETUP) ||
              (next_phase == psram_host_pkg::ST_WR_PULSE) ||
              (next_phase == psram_host_pkg::ST_WR_HOLD);
    end
  end

  // read data capture and completion pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspRdData <= '0;
    end else if (ce) begin
      rspValid <= 1'b0;
      if (phase == psram_host_pkg::ST_RD_ACTIVE && phaseDone && dqSettled) begin
        rspValid <= 1'b1;
        rspRdData <= dqSync;
      end else if (phase == psram_host_pkg::ST_WR_HOLD) begin
        rspValid <= 1'b1; // write completion, data unchanged
      end
    end
  end
endmodule // psram_async_cycle_refresh
`default_nettype wire

/* File: tb/psram_mem_model.sv */
// behavioural pseudo static RAM standing on the far side of the pins
`timescale 1ns/1ns
`default_nettype none
module psram_mem_model (
  input wire logic [psram_host_pkg::ADDR_W-1:0] memAddr,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic output_drive_enable_n,
  input wire logic write_strobe_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic [15:0] dq,
  output logic [15:0] memData,
  output logic memOe,
  output logic refreshLost
);
  logic [15:0] cells [256]; // storage, low address bits only
  logic [15:0] latD; // data seen during the write overlap
  logic latL, latH; // lanes seen during the write overlap
  realtime selT; // moment the select fell
  wire logic sel = !chip_select_low_n && chip_select_high;
  // write only while select and strobe are active and at least one lane is enabled
  wire logic wrAct = sel && !write_strobe_n && !(low_byte_enable_n && high_byte_enable_n);
  initial begin
    refreshLost = 1'b0;
    foreach (cells[i]) cells[i] = '0;
  end
  // drive only selected reads, float as soon as the strobe falls
  assign memOe = sel && !output_drive_enable_n && write_strobe_n;
  // disabled lanes show garbage
  assign memData = cells[memAddr[7:0]] ^ {{8{high_byte_enable_n}}, {8{low_byte_enable_n}}};
  // follow data and lanes up to the terminating edge
  always @(*) begin
    if (wrAct) begin
      latD = dq;
      latL = !low_byte_enable_n;
      latH = !high_byte_enable_n;
    end
  end
  // commit at the end of the overlap, per lane
  always @(negedge wrAct) begin
    if (latL) cells[memAddr[7:0]][7:0] = latD[7:0];
    if (latH) cells[memAddr[7:0]][15:8] = latD[15:8];
  end
  // refresh runs while deselected; a select longer than 15000 ns sets refreshLost
  always @(negedge chip_select_low_n) selT = $realtime;
  always @(posedge chip_select_low_n) begin
    if ($realtime - selT > 15000.0) refreshLost = 1'b1;
  end
endmodule // psram_mem_model
`default_nettype wire

/* File: tb/psram_async_cycle_refresh_assertions.sv */
// pin timing checker for the pseudo static RAM host controller
`timescale 1ns/1ns
`default_nettype none
module psram_async_cycle_refresh_checker #(
  parameter bit SLOW_GRADE = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rspValid,
  input wire logic [psram_host_pkg::ADDR_W-1:0] memAddr,
  input wire logic chip_select_low_n,
  input wire logic chip_select_high,
  input wire logic output_drive_enable_n,
  input wire logic write_strobe_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic [psram_host_pkg::DATA_W-1:0] dqOut,
  input wire logic dqOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int selCycles; // length of the current select-low run
  // counts cycles spent selected
  always_ff @(posedge clk) begin
    if (rst || chip_select_low_n) begin
      selCycles <= 0;
    end else begin
      selCycles <= selCycles + 1;
    end
  end
  read_no_strobe_a: assert property (!output_drive_enable_n |-> write_strobe_n && !dqOe)
    else $error("strobe or data drive during read");
  addr_held_a: assert property (!chip_select_low_n && !$past(chip_select_low_n) |-> $stable(memAddr))
    else $error("address moved while selected");
  strobe_qualified_a: assert property (!write_strobe_n |-> !chip_select_low_n && chip_select_high && output_drive_enable_n && dqOe)
    else $error("strobe low outside full select");
  strobe_width_a: assert property (SLOW_GRADE && $fell(write_strobe_n) |-> !write_strobe_n [*7] ##1 write_strobe_n)
    else $error("strobe width wrong");
  write_stable_a: assert property (!write_strobe_n |-> $stable(dqOut) && $stable(low_byte_enable_n) && $stable(high_byte_enable_n))
    else $error("data or lanes moved in strobe");
  write_end_a: assert property ($rose(write_strobe_n) |-> !chip_select_low_n && !$past(chip_select_low_n, 6) ##1 chip_select_low_n && rspValid)
    else $error("select not held around write end");
  read_length_a: assert property ($fell(chip_select_low_n) && !output_drive_enable_n |-> !chip_select_low_n [*7])
    else $error("read cycle too short");
  deselect_gap_a: assert property ($rose(chip_select_low_n) |=> chip_select_low_n)
    else $error("deselect gap too short");
  select_ceiling_a: assert property (selCycles < psram_host_pkg::REFRESH_WINDOW_CYC)
    else $error("select held too long");
  rsp_pulse_a: assert property (rspValid |=> !rspValid)
    else $error("response longer than a cycle");
endmodule // psram_async_cycle_refresh_checker
bind psram_async_cycle_refresh psram_async_cycle_refresh_checker #(.SLOW_GRADE(SLOW_GRADE)) chk (
  .clk, .rst, .rspValid, .memAddr, .chip_select_low_n, .chip_select_high, .output_drive_enable_n,
  .write_strobe_n, .low_byte_enable_n, .high_byte_enable_n, .dqOut, .dqOe);
`default_nettype wire

/* File: tb/psram_async_cycle_refresh_bench.sv */
// self-checking bench for the pseudo static RAM host controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin numErrors++; $display("[FAIL] %0t mismatch %h %h", $time, g, e); end end
module psram_async_cycle_refresh_bench;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
  logic [18:0] reqAddr = '0, memAddr;
  logic [15:0] reqWrData = '0, rspRdData, dqOut, dqIn, memData, lastDq = '0, lastRd = '0;
  logic [1:0] reqLaneEn = '0;
  logic reqReady, rspValid, chip_select_low_n, chip_select_high, output_drive_enable_n;
  logic write_strobe_n, low_byte_enable_n, high_byte_enable_n, dqOe, memOe, refreshLost;
  logic [16:0] expQ [$]; // notes of {isRead, data}
  logic [15:0] shadow [256]; // expected memory contents
  logic [31:0] lfsr = 32'hc778; // random source
  int numErrors = 0, nChecks = 0;
  always #5 clk = ~clk;
  // shared data bus; floating shows the inverse of the last driven value
  assign dqIn = dqOe ? dqOut : (memOe ? memData : ~lastDq);
  always @(posedge clk) if (dqOe || memOe) lastDq <= dqIn;
  psram_async_cycle_refresh #(.SLOW_GRADE(1'b1)) uut (.clk, .rst, .ce, .reqValid, .reqWrite,
    .reqAddr, .reqWrData, .reqLaneEn, .reqReady, .rspValid, .rspRdData, .memAddr,
    .chip_select_low_n, .chip_select_high, .output_drive_enable_n, .write_strobe_n,
    .low_byte_enable_n, .high_byte_enable_n, .dqOut, .dqOe, .dqIn);
  psram_mem_model mem (.memAddr, .chip_select_low_n, .chip_select_high, .output_drive_enable_n,
    .write_strobe_n, .low_byte_enable_n, .high_byte_enable_n, .dq(dqIn), .memData, .memOe,
    .refreshLost);
  // linear feedback shift register step
  function automatic logic [31:0] nextRand(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // verdict and end of run
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one request: hold until taken, then note the expected answer
  task automatic access(logic wr, logic [18:0] a, logic [15:0] d, logic [1:0] ln);
    int n;
    n = 0;
    @(posedge clk);
    #1 {reqValid, reqWrite, reqAddr, reqWrData, reqLaneEn} = {1'b1, wr, a, d, ln};
    do begin @(posedge clk); n++; end while (reqReady !== 1'b1 && n < 60);
    if (reqReady !== 1'b1) begin numErrors++; reportAndStop(); end
    if (wr && ln[0]) shadow[a[7:0]][7:0] = d[7:0];
    if (wr && ln[1]) shadow[a[7:0]][15:8] = d[15:8];
    expQ.push_back({!wr, wr ? 16'h0000 : shadow[a[7:0]]});
    #1 reqValid = 1'b0;
  endtask
  // wait until every note is answered
  task automatic drain(string name);
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 500) begin @(posedge clk); n++; end
    if (expQ.size() != 0) begin numErrors++; reportAndStop(); end
    $display("test %s done", name);
  endtask
  // compares each response with the oldest note
  // read data must stand unchanged through write completions
  always @(posedge clk) begin
    if (rst) begin
      lastRd = '0;
    end else if (rspValid === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        if (expQ[0][16]) lastRd = expQ[0][15:0];
        `CHK(rspRdData, lastRd)
        void'(expQ.pop_front());
      end
    end
  end
  // main sequence
  initial begin
    foreach (shadow[i]) shadow[i] = '0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    // every lane code, including none
    for (int l = 0; l < 4; l++) begin
      access(1'b1, 19'h10, 16'ha5c3 + 16'(l * 16'h1111), 2'(l));
      access(1'b0, 19'h10, '0, 2'b11);
    end
    drain("lanes");
    // random back-to-back mix
    for (int i = 0; i < 40; i++) begin
      lfsr = nextRand(lfsr);
      access(lfsr[0], {11'h000, lfsr[8:1]}, lfsr[31:16], lfsr[0] ? lfsr[10:9] : 2'b11);
    end
    drain("random");
    // clock enable dropped in the middle of a read
    access(1'b0, 19'h10, '0, 2'b11);
    repeat (2) @(posedge clk);
    #1 ce = 1'b0;
    repeat (3) @(posedge clk);
    #1 ce = 1'b1;
    drain("freeze");
    // reset in the middle of a read, then carry on
    access(1'b0, 19'h11, '0, 2'b11);
    repeat (3) @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    expQ.delete();
    access(1'b1, 19'h12, 16'h3c5a, 2'b11);
    access(1'b0, 19'h12, '0, 2'b11);
    drain("reset");
    `CHK(refreshLost, 1'b0)
    reportAndStop();
  end
endmodule // psram_async_cycle_refresh_bench
`default_nettype wire
